/* File: core/cca_ctrl.sv */
// control, status and alarm logic of the clock calendar, wishbone slave
// assumes rst_n is the power-on reset and oscillator levels are synchronous to clk
module cca_ctrl #(
  parameter int unsigned XTAL_TICKS = cca_pkg::XTAL_HZ,
  parameter int unsigned INT_TICKS  = cca_pkg::INTOSC_HZ
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        sysRst,
  input  wire logic        xtalOsc,
  input  wire logic        intOsc,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             clockPin
);

  localparam int TW = 16;
  localparam int WW = 12;

  cca_pkg::cca_ctrl_s   ctrl;
  cca_pkg::cca_alarm_s  alarm;
  cca_pkg::cca_unlock_e unlockState;
  logic [23:0]          alarmTime;
  logic [31:0]          ctrlRd;
  logic [31:0]          alrmRd;
  logic [31:0]          rdData;
  logic [31:0]          wrMerged;
  logic                 access;
  logic                 wrStb;
  logic                 wrCtrl;
  logic                 wrAlrm;
  logic                 wrAtime;
  logic                 wrTime;
  logic                 wrKey;
  logic                 oscLvl;
  logic                 oscPrev;
  logic                 oscTick;
  logic [TW-1:0]        ticksPerSec;
  logic [2:0]           loadLane;
  logic [23:0]          timeVal;
  logic                 secPulse;
  logic                 half_second_status;
  logic                 ripple;
  logic                 secSeen;
  logic                 alarmEvt;
  logic                 clkOn;
  logic                 xtalPrev;
  logic [WW-1:0]        xtalIdle;
  logic                 alarmSync;

  // byte-lane merge of a write into the current register image
  function automatic logic [31:0] byteMerge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : byteMerge

  // ********************************************************************
  // bus slave
  // ********************************************************************
  assign access = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wrStb  = access && wb_we_i;

  // one decode per register, shared by every process that reacts to a write
  assign wrCtrl  = wrStb && wb_adr_i == cca_pkg::OFS_CTRL;
  assign wrAlrm  = wrStb && wb_adr_i == cca_pkg::OFS_ALRM;
  assign wrAtime = wrStb && wb_adr_i == cca_pkg::OFS_ATIME;
  assign wrTime  = wrStb && wb_adr_i == cca_pkg::OFS_TIME;
  assign wrKey   = wrStb && wb_adr_i == cca_pkg::OFS_KEY;

  // single wait state: ack one cycle after the request, dropped the next
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
    end else if (sysRst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= access;
    end
  end

  // read data holds until the next read, so a late sample still sees it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (access && !wb_we_i) begin
      wb_dat_o <= rdData;
    end
  end

  always_comb begin
    ctrlRd                                       = 32'h0000_0000;
    ctrlRd[cca_pkg::CTRL_ON_BIT]                 = ctrl.on;
    ctrlRd[cca_pkg::CTRL_CSEL_LSB +: 2]          = ctrl.clkSel;
    ctrlRd[cca_pkg::CTRL_OSEL_LSB +: 2]          = ctrl.outSel;
    ctrlRd[cca_pkg::CTRL_CLKON_BIT]              = clkOn;
    ctrlRd[cca_pkg::CTRL_WREN_BIT]               = ctrl.wrEn;
    ctrlRd[cca_pkg::CTRL_SYNC_BIT]               = ripple && ctrl.on;
    ctrlRd[cca_pkg::CTRL_HALF_BIT]               = half_second_status;
    ctrlRd[cca_pkg::CTRL_OE_BIT]                 = ctrl.oe;
  end

  always_comb begin
    alrmRd                                       = 32'h0000_0000;
    alrmRd[cca_pkg::ALRM_EN_BIT]                 = alarm.en;
    alrmRd[cca_pkg::ALRM_CHIME_BIT]              = alarm.chime;
    alrmRd[cca_pkg::ALRM_SYNC_BIT]               = alarmSync;
    alrmRd[7:0]                                  = alarm.rpt;
  end

  // unmapped offsets read zero and swallow writes
  always_comb begin
    unique case (wb_adr_i)
      cca_pkg::OFS_CTRL:  rdData = ctrlRd;
      cca_pkg::OFS_ALRM:  rdData = alrmRd;
      cca_pkg::OFS_ATIME: rdData = {alarmTime, 8'h00};
      cca_pkg::OFS_TIME:  rdData = {timeVal, 8'h00};
      default:            rdData = 32'h0000_0000;
    endcase
  end

  always_comb begin
    unique case (wb_adr_i)
      cca_pkg::OFS_CTRL: wrMerged = byteMerge(ctrlRd, wb_dat_i, wb_sel_i);
      cca_pkg::OFS_ALRM: wrMerged = byteMerge(alrmRd, wb_dat_i, wb_sel_i);
      default:           wrMerged = byteMerge({alarmTime, 8'h00}, wb_dat_i, wb_sel_i);
    endcase
  end

  // ********************************************************************
  // unlock sequence
  // ********************************************************************
  // two full-word keys back to back; any other key write starts over.
  // setting write enable consumes the unlock so a stray write cannot relock-open
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      unlockState <= cca_pkg::UL_IDLE;
    end else if (sysRst) begin
      unlockState <= cca_pkg::UL_IDLE;
    end else if (wrKey) begin
      if (wb_sel_i == 4'hF && wb_dat_i == cca_pkg::UNLOCK_KEY1) begin
        unlockState <= cca_pkg::UL_KEY1;
      end else if (wb_sel_i == 4'hF && wb_dat_i == cca_pkg::UNLOCK_KEY2
                   && unlockState == cca_pkg::UL_KEY1) begin
        unlockState <= cca_pkg::UL_OPEN;
      end else begin
        unlockState <= cca_pkg::UL_IDLE;
      end
    end else if (wrCtrl && wrMerged[cca_pkg::CTRL_WREN_BIT]
                 && !ctrl.wrEn) begin
      unlockState <= cca_pkg::UL_IDLE;
    end
  end

  // ********************************************************************
  // control register
  // ********************************************************************
  // sysRst is a non-power-on reset: it never touches this state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= cca_pkg::CTRL_RESET;
    end else if (wrCtrl) begin
      ctrl.clkSel <= wrMerged[cca_pkg::CTRL_CSEL_LSB +: 2];
      ctrl.outSel <= wrMerged[cca_pkg::CTRL_OSEL_LSB +: 2];
      ctrl.oe     <= wrMerged[cca_pkg::CTRL_OE_BIT];
      if (!wrMerged[cca_pkg::CTRL_WREN_BIT]) begin
        ctrl.wrEn <= 1'b0;
      end else if (unlockState == cca_pkg::UL_OPEN) begin
        ctrl.wrEn <= 1'b1;
      end
      if (ctrl.wrEn) begin
        ctrl.on <= wrMerged[cca_pkg::CTRL_ON_BIT];
      end
    end
  end

  // ********************************************************************
  // timekeeping source and time value
  // ********************************************************************
  // reserved source codes leave the prescaler without ticks
  always_comb begin
    unique case (ctrl.clkSel)
      cca_pkg::CSEL_XTAL:   oscLvl = xtalOsc;
      cca_pkg::CSEL_INTOSC: oscLvl = intOsc;
      default:              oscLvl = 1'b0;
    endcase
  end

  // prescaler length of the chosen source; reserved codes reuse the internal count
  function automatic logic [TW-1:0] secTicks(input logic [1:0] sel);
    if (sel == cca_pkg::CSEL_XTAL) begin
      return TW'(XTAL_TICKS);
    end else begin
      return TW'(INT_TICKS);
    end
  endfunction : secTicks

  assign ticksPerSec = secTicks(ctrl.clkSel);
  // ticks only while on, so a switched-off module keeps its time frozen
  assign oscTick     = oscLvl && !oscPrev && ctrl.on;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      oscPrev <= 1'b0;
    end else begin
      oscPrev <= oscLvl;
    end
  end

  // locked writes to the time register are dropped outright
  assign loadLane = (wrTime && ctrl.wrEn)
                    ? wb_sel_i[3:1] : 3'b000;

  cca_timebase #(
    .TW (TW)
  ) u_timebase (
    .clk         (clk),
    .rst_n       (rst_n),
    .tick        (oscTick),
    .ticksPerSec (ticksPerSec),
    .loadLane    (loadLane),
    .loadVal     (wb_dat_i[31:cca_pkg::TIME_LSB]),
    .timeVal     (timeVal),
    .secPulse    (secPulse),
    .half_second_status     (half_second_status),
    .ripple      (ripple)
  );

  // ********************************************************************
  // clock running status
  // ********************************************************************
  // watchdog on crystal edges; meaningless with the internal source
  // a long window tolerates a slow crystal but reports a stop late
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      xtalPrev <= 1'b0;
      xtalIdle <= WW'(cca_pkg::CLKON_WIN_CYC);
      clkOn    <= 1'b0;
    end else begin
      xtalPrev <= xtalOsc;
      if (xtalOsc != xtalPrev) begin
        xtalIdle <= '0;
      end else if (xtalIdle != WW'(cca_pkg::CLKON_WIN_CYC)) begin
        xtalIdle <= xtalIdle + WW'(1);
      end
      clkOn <= ctrl.on && ctrl.clkSel == cca_pkg::CSEL_XTAL
               && xtalIdle != WW'(cca_pkg::CLKON_WIN_CYC);
    end
  end

  // ********************************************************************
  // alarm
  // ********************************************************************
  // compare one cycle after the second ticks so the new time is settled
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      secSeen  <= 1'b0;
      alarmEvt <= 1'b0;
    end else begin
      secSeen  <= secPulse;
      alarmEvt <= secSeen && alarm.en && ctrl.on && timeVal == alarmTime;
    end
  end

  // warns software off the repeat count while a rollover may land
  assign alarmSync = alarm.en && ctrl.on && ripple;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alarmTime <= cca_pkg::TIME_RESET;
    end else if (wrAtime) begin
      alarmTime <= wrMerged[31:cca_pkg::TIME_LSB];
    end
  end

  // event handling follows the bus write so hardware wins a same-cycle clash
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alarm <= cca_pkg::ALARM_RESET;
    end else begin
      if (wrAlrm) begin
        alarm.en    <= wrMerged[cca_pkg::ALRM_EN_BIT];
        alarm.chime <= wrMerged[cca_pkg::ALRM_CHIME_BIT];
        alarm.rpt   <= wrMerged[7:0];
      end
      if (alarmEvt) begin
        if (alarm.rpt == 8'h00 && !alarm.chime) begin
          alarm.en <= 1'b0;
        end else begin
          alarm.rpt <= alarm.rpt - 8'h01;
        end
      end
    end
  end

  // ********************************************************************
  // clock output pin
  // ********************************************************************
  // registered so the pin never glitches while the select changes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clockPin <= 1'b0;
    end else if (!ctrl.oe) begin
      clockPin <= 1'b0;
    end else begin
      unique case (ctrl.outSel)
        cca_pkg::OSEL_CLK:   clockPin <= oscLvl;
        cca_pkg::OSEL_SEC:   clockPin <= half_second_status;
        cca_pkg::OSEL_ALARM: clockPin <= alarmEvt;
        default:             clockPin <= 1'b0;
      endcase
    end
  end

endmodule : cca_ctrl

/* File: core/cca_pkg.sv */
// constants, field layouts and carrier types of the clock calendar alarm block
// assumes one 20 MHz clock and a classic wishbone register bus with 32-bit data
package cca_pkg;

  // ********************************************************************
  // timing
  // ********************************************************************
  localparam int unsigned CLK_HZ         = 20_000_000;
  localparam int unsigned XTAL_HZ        = 32_768;
  localparam int unsigned INTOSC_HZ      = 32_000;
  // running-status window: no oscillator edge for this long means stopped
  localparam int unsigned CLKON_WIN_NS   = 100_000;
  localparam int unsigned CLKON_WIN_CYC  = (CLKON_WIN_NS * (CLK_HZ / 1_000_000)) / 1_000;
  // prescaler ticks before rollover during which reads may ripple
  localparam int unsigned SYNC_TICKS     = 32;

  // ********************************************************************
  // register byte offsets
  // ********************************************************************
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_ALRM  = 8'h04;
  localparam logic [7:0] OFS_ATIME = 8'h08;
  localparam logic [7:0] OFS_TIME  = 8'h0C;
  localparam logic [7:0] OFS_KEY   = 8'h10;

  // ********************************************************************
  // field positions
  // ********************************************************************
  localparam int CTRL_ON_BIT    = 15;
  localparam int CTRL_CSEL_LSB  = 9;
  localparam int CTRL_OSEL_LSB  = 7;
  localparam int CTRL_CLKON_BIT = 6;
  localparam int CTRL_WREN_BIT  = 3;
  localparam int CTRL_SYNC_BIT  = 2;
  localparam int CTRL_HALF_BIT  = 1;
  localparam int CTRL_OE_BIT    = 0;
  localparam int ALRM_EN_BIT    = 15;
  localparam int ALRM_CHIME_BIT = 14;
  localparam int ALRM_SYNC_BIT  = 12;
  localparam int TIME_LSB       = 8;

  // ********************************************************************
  // codes and reset values
  // ********************************************************************
  localparam logic [1:0] CSEL_INTOSC = 2'h0;
  localparam logic [1:0] CSEL_XTAL   = 2'h1;
  localparam logic [1:0] OSEL_ALARM  = 2'h0;
  localparam logic [1:0] OSEL_SEC    = 2'h1;
  localparam logic [1:0] OSEL_CLK    = 2'h2;
  localparam logic [7:0] RPT_RESET   = 8'h00;
  localparam logic [23:0] TIME_RESET = 24'h00_0000;
  // unlock key words: values are arbitrary
  localparam logic [31:0] UNLOCK_KEY1 = 32'h5A5A_0001;
  localparam logic [31:0] UNLOCK_KEY2 = 32'hA5A5_0002;

  typedef struct packed {
    logic       on;
    logic [1:0] clkSel;
    logic [1:0] outSel;
    logic       wrEn;
    logic       oe;
  } cca_ctrl_s;

  typedef struct packed {
    logic       en;
    logic       chime;
    logic [7:0] rpt;
  } cca_alarm_s;

  localparam cca_ctrl_s  CTRL_RESET  = '{on: 1'b0, clkSel: CSEL_INTOSC, outSel: OSEL_ALARM,
                                         wrEn: 1'b0, oe: 1'b0};
  localparam cca_alarm_s ALARM_RESET = '{en: 1'b0, chime: 1'b0, rpt: RPT_RESET};

  typedef enum logic [1:0] {UL_IDLE, UL_KEY1, UL_OPEN} cca_unlock_e;

endpackage : cca_pkg

/* File: core/cca_timebase.sv */
// prescaler and bcd hours/minutes/seconds counter of the clock calendar
// assumes tick is a one-cycle pulse per oscillator period, synchronous to clk
module cca_timebase #(
  parameter int TW = 16
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          tick,
  input  wire logic [TW-1:0] ticksPerSec,
  input  wire logic [2:0]    loadLane,
  input  wire logic [23:0]   loadVal,
  output logic      [23:0]   timeVal,
  output logic               secPulse,
  output logic               half_second_status,
  output logic               ripple
);

  logic [TW-1:0] preCnt;
  logic          wrapNow;

  // one step of a two-digit bcd value; bit 8 flags the wrap to zero
  function automatic logic [8:0] bcdStep(input logic [7:0] v, input logic [7:0] last);
    if (v == last) begin
      return 9'h100;
    end else if (v[3:0] == 4'h9) begin
      return {1'b0, v[7:4] + 4'h1, 4'h0};
    end else begin
      return {1'b0, v[7:4], v[3:0] + 4'h1};
    end
  endfunction : bcdStep

  assign wrapNow  = tick && (preCnt == ticksPerSec - TW'(1));
  assign half_second_status  = preCnt >= (ticksPerSec >> 1);
  assign ripple   = preCnt >= ticksPerSec - TW'(cca_pkg::SYNC_TICKS);

  // ********************************************************************
  // prescaler
  // ********************************************************************
  // writing seconds restarts the second, so the prescaler starts clean
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      preCnt <= '0;
    end else if (loadLane[0]) begin
      preCnt <= '0;
    end else if (wrapNow) begin
      preCnt <= '0;
    end else if (tick) begin
      preCnt <= preCnt + TW'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      secPulse <= 1'b0;
    end else begin
      secPulse <= wrapNow && !loadLane[0];
    end
  end

  // ********************************************************************
  // bcd time counter
  // ********************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    logic [8:0] s;
    logic [8:0] m;
    logic [8:0] h;
    if (!rst_n) begin
      timeVal <= cca_pkg::TIME_RESET;
    end else begin
      s = bcdStep(timeVal[7:0], 8'h59);
      m = bcdStep(timeVal[15:8], 8'h59);
      h = bcdStep(timeVal[23:16], 8'h23);
      if (wrapNow) begin
        timeVal[7:0] <= s[7:0];
        if (s[8]) begin
          timeVal[15:8] <= m[7:0];
          if (m[8]) begin
            timeVal[23:16] <= h[7:0];
          end
        end
      end
      if (loadLane[0]) begin
        timeVal[7:0] <= loadVal[7:0];
      end
      if (loadLane[1]) begin
        timeVal[15:8] <= loadVal[15:8];
      end
      if (loadLane[2]) begin
        timeVal[23:16] <= loadVal[23:16];
      end
    end
  end

endmodule : cca_timebase

/* File: bench/cca_ctrl_checker.sv */
// port checker of the clock calendar control block
// assumes bind onto cca_ctrl and full byte enables on control writes
module cca_ctrl_checker #(
  parameter int unsigned XTAL_TICKS = 64,
  parameter int unsigned INT_TICKS  = 64
) (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        sysRst,
  input wire logic        xtalOsc,
  input wire logic        intOsc,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        clockPin
);
  // ****
  // shadow of pin controls
  // ****
  logic       oeS;
  logic [1:0] oselS;
  logic [1:0] cselS;
  wire  logic taken = wb_cyc_i && wb_stb_i && !wb_ack_o && !sysRst;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      oeS   <= 1'b0;
      oselS <= 2'h0;
      cselS <= 2'h0;
    end else if (taken && wb_we_i && wb_adr_i == cca_pkg::OFS_CTRL) begin
      oeS   <= wb_dat_i[0];
      oselS <= wb_dat_i[8:7];
      cselS <= wb_dat_i[10:9];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_read;
    taken && !wb_we_i;
  endsequence
  sequence s_mode(logic [1:0] m);
    oeS && oselS == m && $past(oeS) && $past(oselS) == m;
  endsequence
  a_ack_next: assert property (taken |=> wb_ack_o)
    else $error("no ack one cycle after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_pin_off: assert property (!oeS && !$past(oeS) |-> !clockPin)
    else $error("pin active with output disabled");
  a_pin_reserved: assert property (s_mode(2'h3) |-> !clockPin)
    else $error("pin active in reserved mode");
  a_pin_pulse: assert property (s_mode(2'h0) ##0 clockPin |=> !clockPin)
    else $error("alarm pulse longer than one cycle");
  a_pin_clock: assert property (s_mode(2'h2) ##0 cselS == 2'h1
    && $past(cselS) == 2'h1 |-> clockPin == $past(xtalOsc))
    else $error("pin does not follow the crystal");
  a_unmapped_zero: assert property (s_read ##0 (wb_adr_i[1:0] != 2'h0
    || wb_adr_i >= cca_pkg::OFS_KEY) |=> wb_dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_time_low: assert property (s_read ##0 (wb_adr_i == cca_pkg::OFS_ATIME
    || wb_adr_i == cca_pkg::OFS_TIME) |=> wb_dat_o[7:0] == 8'h00)
    else $error("time low byte not zero");
endmodule : cca_ctrl_checker

bind cca_ctrl cca_ctrl_checker #(.XTAL_TICKS(XTAL_TICKS), .INT_TICKS(INT_TICKS)) u_chk (
  .clk(clk), .rst_n(rst_n), .sysRst(sysRst), .xtalOsc(xtalOsc), .intOsc(intOsc),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .clockPin(clockPin));

/* File: bench/testbench.sv */
// self-checking bench of the clock calendar control block
// assumes short second counts so a second is 512 clock cycles
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // stimulus and checks
  // ****
  localparam int unsigned TICKS = 64;
  localparam logic [31:0] CMASK = 32'h0000_8789;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  logic        clk = 1'b0;
  logic        rstN = 1'b0;
  logic        sysRst = 1'b0;
  logic        xtalOsc = 1'b0;
  logic        intOsc = 1'b0;
  logic        xtalRun = 1'b1;
  logic        wbCyc = 1'b0;
  logic        wbStb = 1'b0;
  logic        wbWe = 1'b0;
  logic [7:0]  wbAdr = 8'h00;
  logic [3:0]  wbSel = 4'h0;
  logic [3:0]  laneSel = 4'hF;
  logic [31:0] wbDat = 32'h0000_0000;
  logic [31:0] wbDatO;
  logic        wbAck;
  logic        clockPin;
  logic [31:0] seed = 32'h0000_005F;
  logic [31:0] full;
  logic [31:0] t;
  logic [31:0] aIn [3] = '{32'h0000_8002, 32'h0000_C000, 32'h0000_8000};
  logic [31:0] aOut [3] = '{32'h0000_8001, 32'h0000_C0FF, 32'h0000_0000};
  int          ones;
  int          badCount = 0;
  int          samplesChecked = 0;

  cca_ctrl #(.XTAL_TICKS(TICKS), .INT_TICKS(TICKS)) dut (
    .clk(clk), .rst_n(rstN), .sysRst(sysRst), .xtalOsc(xtalOsc), .intOsc(intOsc),
    .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
    .wb_sel_i(wbSel), .wb_dat_i(wbDat), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
    .clockPin(clockPin));

  initial begin
    forever #25 clk = ~clk;
  end
  // rising oscillator edge every 8 cycles, so 64 ticks make one second
  initial begin
    forever begin
      repeat (4) @(posedge clk);
      if (xtalRun) xtalOsc <= ~xtalOsc;
      intOsc <= ~intOsc;
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // digits kept legal; hours below 20 keeps it simple
  function automatic logic [31:0] bcd();
    logic [31:0] r;
    r = rnd();
    return {3'h0, r[0], r[7:4] % 4'd10, r[11:8] % 4'd6, r[15:12] % 4'd10,
            r[19:16] % 4'd6, r[23:20] % 4'd10, r[31:24]};
  endfunction : bcd
  function automatic logic [31:0] ctrlW(logic on, logic [1:0] cs, logic [1:0] os,
                                        logic wren, logic oe);
    return {16'h0, on, 4'h0, cs, os, 3'h0, wren, 2'h0, oe};
  endfunction : ctrlW

  task automatic printVerdict();
    $display("checked %0d mismatches %0d", samplesChecked, badCount);
    if (badCount == 0 && samplesChecked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : printVerdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      badCount++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe  <= w;
    wbAdr <= a;
    wbDat <= d;
    wbSel <= laneSel;
    do @(posedge clk); while (wbAck !== 1'b1 && ++n < 20);
    if (n >= 20) chk(32'h0000_0000, 32'h0000_0001);
    q = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0000_0000, q);
    chk(q & m, e);
  endtask : rd
  task automatic pinCount(input int n);
    ones = 0;
    repeat (n) begin
      @(posedge clk);
      #1 ones += int'(clockPin === 1'b1);
    end
  endtask : pinCount

  initial begin
    repeat (10) @(posedge clk);
    rstN <= 1'b1;
    for (int i = 0; i < 4; i++) rd(8'(4 * i), ALL, 32'h0000_0000);
    wr(cca_pkg::OFS_CTRL, ctrlW(1'b1, cca_pkg::CSEL_XTAL, cca_pkg::OSEL_CLK, 1'b1, 1'b1));
    rd(cca_pkg::OFS_CTRL, CMASK, ctrlW(1'b0, 2'h1, 2'h2, 1'b0, 1'b1));
    wr(cca_pkg::OFS_TIME, 32'h1234_5600);
    rd(cca_pkg::OFS_TIME, ALL, 32'h0000_0000);
    wr(cca_pkg::OFS_KEY, cca_pkg::UNLOCK_KEY1);
    wr(cca_pkg::OFS_KEY, cca_pkg::UNLOCK_KEY2);
    full = ctrlW(1'b1, cca_pkg::CSEL_XTAL, cca_pkg::OSEL_CLK, 1'b1, 1'b1);
    wr(cca_pkg::OFS_CTRL, full);
    // on only takes once write enable already stands
    wr(cca_pkg::OFS_CTRL, full);
    rd(cca_pkg::OFS_CTRL, CMASK, full);
    pinCount(64);
    chk(32'(ones > 0 && ones < 64), 32'h0000_0001);
    t = bcd();
    wr(cca_pkg::OFS_TIME, t);
    rd(cca_pkg::OFS_TIME, ALL, {t[31:8], 8'h00});
    rd(cca_pkg::OFS_CTRL, 32'h0000_0006, 32'h0000_0000);
    repeat (300) @(posedge clk);
    rd(cca_pkg::OFS_CTRL, 32'h0000_0046, 32'h0000_0046);
    laneSel = 4'h2;
    wr(cca_pkg::OFS_TIME, t);
    laneSel = 4'hF;
    rd(cca_pkg::OFS_CTRL, 32'h0000_0002, 32'h0000_0000);
    sysRst <= 1'b1;
    @(posedge clk);
    sysRst <= 1'b0;
    rd(cca_pkg::OFS_CTRL, CMASK, full);
    rd(cca_pkg::OFS_TIME, ALL, {t[31:8], 8'h00});
    wr(cca_pkg::OFS_CTRL, ctrlW(1'b1, 2'h1, cca_pkg::OSEL_ALARM, 1'b1, 1'b1));
    for (int i = 0; i < 3; i++) begin
      wr(cca_pkg::OFS_ATIME, 32'h0000_0100);
      wr(cca_pkg::OFS_TIME, 32'h0000_0000);
      // second just restarted, so no rollover is near this write
      wr(cca_pkg::OFS_ALRM, aIn[i]);
      pinCount(600);
      chk(32'(ones), 32'h0000_0001);
      rd(cca_pkg::OFS_ALRM, 32'h0000_C0FF, aOut[i]);
    end
    for (int i = 0; i < 4; i++) begin
      t = bcd();
      wr(cca_pkg::OFS_ATIME, t);
      rd(cca_pkg::OFS_ATIME, ALL, {t[31:8], 8'h00});
    end
    rd(8'h14, ALL, 32'h0000_0000);
    rd(8'h02, ALL, 32'h0000_0000);
    rd(cca_pkg::OFS_KEY, ALL, 32'h0000_0000);
    wr(cca_pkg::OFS_CTRL, ctrlW(1'b1, cca_pkg::CSEL_INTOSC, cca_pkg::OSEL_SEC, 1'b1, 1'b1));
    wr(cca_pkg::OFS_TIME, t);
    pinCount(512);
    chk(32'(ones >= 250 && ones <= 262), 32'h0000_0001);
    for (int i = 0; i < 2; i++) begin
      wr(cca_pkg::OFS_CTRL, ctrlW(1'b1, 2'h1, i ? 2'h3 : 2'h2, 1'b1, 1'(i)));
      pinCount(64);
      chk(32'(ones), 32'h0000_0000);
    end
    wr(cca_pkg::OFS_CTRL, full);
    xtalRun <= 1'b0;
    repeat (2100) @(posedge clk);
    rd(cca_pkg::OFS_CTRL, 32'h0000_0040, 32'h0000_0000);
    printVerdict();
  end
  // whole run is near 5000 cycles
  initial begin
    repeat (40000) @(posedge clk);
    badCount++;
    printVerdict();
  end
endmodule : testbench
